// [shared/fault_flag_pkg.sv]
// package: offsets, field positions, fault ids and sync indices for the fault flag status bank
package fault_flag_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ID_W = 4;
  localparam int NUM_FAULTS = 15;

  // register byte addresses
  localparam logic [15:0] ADDR_FLAGS_FOUR = 16'hfec3;
  localparam logic [15:0] ADDR_FLAGS_FIVE = 16'hfec4;
  localparam logic [15:0] ADDR_FLAGS_FIVE_STICKY = 16'hfec9;
  localparam logic [15:0] ADDR_CHAN_A_CAUSE = 16'hfeca;
  localparam logic [15:0] ADDR_CHAN_B_CAUSE = 16'hfecb;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'hfed0;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hfed1;

  // condition_flags_four bit positions
  localparam int F4_SUPPLY_C_OFF = 6;
  localparam int F4_FLAG_PIN = 5;
  localparam int F4_NVM_UNLOCKED = 4;
  localparam int F4_RAMP_B = 3;
  localparam int F4_RAMP_A = 2;
  localparam int F4_CLAMP_B = 1;
  localparam int F4_CLAMP_A = 0;

  // condition_flags_five bit positions
  localparam int F5_ZONE2_WARN = 3;
  localparam int F5_ZONE1_WARN = 2;
  localparam int F5_REV_B = 1;
  localparam int F5_REV_A = 0;
  localparam int F5_W = 4;

  // shutdown cause field layout
  localparam int CUR_LSB = 0;
  localparam int PREV_LSB = 4;

  // fault ids
  localparam logic [3:0] ID_NONE = 4'h0;
  localparam logic [3:0] ID_PRI_OC_A = 4'h1;
  localparam logic [3:0] ID_PRI_OC_B = 4'h2;
  localparam logic [3:0] ID_SEC_OC_A = 4'h3;
  localparam logic [3:0] ID_SEC_OC_B = 4'h4;
  localparam logic [3:0] ID_OV_A = 4'h5;
  localparam logic [3:0] ID_OV_B = 4'h6;
  localparam logic [3:0] ID_UV_A = 4'h7;
  localparam logic [3:0] ID_UV_B = 4'h8;
  localparam logic [3:0] ID_SHARED_OC = 4'h9;
  localparam logic [3:0] ID_LINE_SENSE = 4'ha;
  localparam logic [3:0] ID_ZONE1_OT = 4'hb;
  localparam logic [3:0] ID_ZONE2_OT = 4'hc;
  localparam logic [3:0] ID_EXT_FLAG = 4'hd;
  localparam logic [3:0] ID_REV_A = 4'he;
  localparam logic [3:0] ID_REV_B = 4'hf;

  // interrupt status bit positions
  localparam int IRQ_CAUSE_A = 0;
  localparam int IRQ_CAUSE_B = 1;
  localparam int IRQ_STICKY = 2;
  localparam int IRQ_W = 3;

  // positions of asynchronous inputs in the synchroniser vector (faults sit at id-1)
  localparam int S_LIGHT_A = 15;
  localparam int S_LIGHT_B = 16;
  localparam int S_RAMP_A = 17;
  localparam int S_RAMP_B = 18;
  localparam int S_CLAMP_A = 19;
  localparam int S_CLAMP_B = 20;
  localparam int S_UNLOCKED = 21;
  localparam int S_ZONE1_WARN = 22;
  localparam int S_ZONE2_WARN = 23;
  localparam int S_C_OFF = 24;
  localparam int S_C_REQ = 25;
  localparam int S_RUN_A = 26;
  localparam int S_RUN_B = 27;
  localparam int SYNC_W = 28;

  typedef enum logic [2:0] {
    REC_IDLE = 3'b001,
    REC_ARMED = 3'b010,
    REC_HELD = 3'b100
  } rec_state_type;

endpackage

// [logic/fault_flag_status_bank.sv]
// fault flag status bank: live and sticky condition flags plus per-channel shutdown cause recorders
`timescale 1ns/1ps

// Operation
// - channel c off bit holds until power-on request
// - bit 5 shows flag pin driven by light-load
// - bit 4 set while config memory unlocked
// - bits 3,2 show ramp filters of b,a
// - bits 1,0 show loop filter clamped b,a
// - fifth register bits 3,2 zone temperature warnings
// - fifth register bits 0,1 reverse current a,b
// - flags one when present; reserved bits read zero
// - fifth flags live and sticky at separate addresses
// - one shutdown cause register per regulated channel
// - only earliest shutdown-triggering flag is recorded
// - bits 7:4 hold previous shutdown cause id
// - ids 0..9: none, overcurrents, over/undervoltage, shared
// - bits 3:0 hold most recent shutdown cause
module fault_flag_status_bank (
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [fault_flag_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fault_flag_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [fault_flag_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  // protection comparators and sequencing, asynchronous to clk_sys
  input wire logic chan_a_primary_overcurrent,
  input wire logic chan_b_primary_overcurrent,
  input wire logic chan_a_secondary_overcurrent,
  input wire logic chan_b_secondary_overcurrent,
  input wire logic chan_a_overvoltage,
  input wire logic chan_b_overvoltage,
  input wire logic chan_a_undervoltage,
  input wire logic chan_b_undervoltage,
  input wire logic shared_overcurrent,
  input wire logic line_sense_low,
  input wire logic zone1_overtemp,
  input wire logic zone2_overtemp,
  input wire logic external_flag_input,
  input wire logic chan_a_secondary_sense,
  input wire logic chan_b_secondary_sense,
  input wire logic chan_a_light_load,
  input wire logic chan_b_light_load,
  input wire logic chan_a_ramp_filter_active,
  input wire logic chan_b_ramp_filter_active,
  input wire logic chan_a_loop_filter_clamped,
  input wire logic chan_b_loop_filter_clamped,
  input wire logic nvm_unlocked,
  input wire logic zone1_temp_warning,
  input wire logic zone2_temp_warning,
  input wire logic chan_c_outputs_off,
  input wire logic chan_c_power_on_request,
  input wire logic chan_a_running,
  input wire logic chan_b_running,
  // configuration from the same clock domain
  input wire logic flag_pin_light_load_enable,
  input wire logic [fault_flag_pkg::NUM_FAULTS-1:0] chan_a_shutdown_enables,
  input wire logic [fault_flag_pkg::NUM_FAULTS-1:0] chan_b_shutdown_enables,
  output logic flag_out_sync_out_pin
);
  import fault_flag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // lowest set index wins when several flags rise together
  function automatic logic [ID_W-1:0] first_id(input logic [NUM_FAULTS-1:0] hits);
    logic [ID_W-1:0] id;
    id = ID_NONE;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (hits[i]) begin
        id = ID_W'(i + 1);
      end
    end
    return id;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return a == b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;

  // vector index + 1 is the fault id
  assign raw_in[ID_PRI_OC_A-1] = chan_a_primary_overcurrent;
  assign raw_in[ID_PRI_OC_B-1] = chan_b_primary_overcurrent;
  assign raw_in[ID_SEC_OC_A-1] = chan_a_secondary_overcurrent;
  assign raw_in[ID_SEC_OC_B-1] = chan_b_secondary_overcurrent;
  assign raw_in[ID_OV_A-1] = chan_a_overvoltage;
  assign raw_in[ID_OV_B-1] = chan_b_overvoltage;
  assign raw_in[ID_UV_A-1] = chan_a_undervoltage;
  assign raw_in[ID_UV_B-1] = chan_b_undervoltage;
  assign raw_in[ID_SHARED_OC-1] = shared_overcurrent;
  assign raw_in[ID_LINE_SENSE-1] = line_sense_low;
  assign raw_in[ID_ZONE1_OT-1] = zone1_overtemp;
  assign raw_in[ID_ZONE2_OT-1] = zone2_overtemp;
  assign raw_in[ID_EXT_FLAG-1] = external_flag_input;
  assign raw_in[ID_REV_A-1] = chan_a_secondary_sense;
  assign raw_in[ID_REV_B-1] = chan_b_secondary_sense;
  assign raw_in[S_LIGHT_A] = chan_a_light_load;
  assign raw_in[S_LIGHT_B] = chan_b_light_load;
  assign raw_in[S_RAMP_A] = chan_a_ramp_filter_active;
  assign raw_in[S_RAMP_B] = chan_b_ramp_filter_active;
  assign raw_in[S_CLAMP_A] = chan_a_loop_filter_clamped;
  assign raw_in[S_CLAMP_B] = chan_b_loop_filter_clamped;
  assign raw_in[S_UNLOCKED] = nvm_unlocked;
  assign raw_in[S_ZONE1_WARN] = zone1_temp_warning;
  assign raw_in[S_ZONE2_WARN] = zone2_temp_warning;
  assign raw_in[S_C_OFF] = chan_c_outputs_off;
  assign raw_in[S_C_REQ] = chan_c_power_on_request;
  assign raw_in[S_RUN_A] = chan_a_running;
  assign raw_in[S_RUN_B] = chan_b_running;

  // only sync_r is read past this point; meta_r may still be settling
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  logic [NUM_FAULTS-1:0] fault_now;
  assign fault_now = sync_r[NUM_FAULTS-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic sel_four;
  logic sel_five;
  logic sel_sticky;
  logic sel_cause_a;
  logic sel_cause_b;
  logic sel_status;
  logic sel_mask;
  logic wr_sticky;
  logic wr_status;
  logic wr_mask;

  assign sel_four = hit(reg_addr, ADDR_FLAGS_FOUR);
  assign sel_five = hit(reg_addr, ADDR_FLAGS_FIVE);
  assign sel_sticky = hit(reg_addr, ADDR_FLAGS_FIVE_STICKY);
  assign sel_cause_a = hit(reg_addr, ADDR_CHAN_A_CAUSE);
  assign sel_cause_b = hit(reg_addr, ADDR_CHAN_B_CAUSE);
  assign sel_status = hit(reg_addr, ADDR_IRQ_STATUS);
  assign sel_mask = hit(reg_addr, ADDR_IRQ_MASK);
  // only the sticky copy and the interrupt pair take writes; all else is read-only
  assign wr_sticky = reg_write && sel_sticky;
  assign wr_status = reg_write && sel_status;
  assign wr_mask = reg_write && sel_mask;

  ////////////////////////////////////////////////////////////////////////////
  // condition_flags_four

  logic supply_c_off_r;
  logic supply_c_off_nxt;
  logic c_off_seen;
  logic c_on_req;
  logic light_any;
  logic flag_pin_nxt;

  assign c_off_seen = sync_r[S_C_OFF];
  assign c_on_req = sync_r[S_C_REQ];
  assign light_any = sync_r[S_LIGHT_A] || sync_r[S_LIGHT_B];
  // set wins over the request so an off channel never reads as on
  assign supply_c_off_nxt = c_off_seen ? 1'b1 : (c_on_req ? 1'b0 : supply_c_off_r);
  // the pin and bit 5 come from one flop, so software never sees them disagree
  assign flag_pin_nxt = flag_pin_light_load_enable && light_any;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      supply_c_off_r <= 1'b1;
      flag_out_sync_out_pin <= 1'b0;
    end else begin
      supply_c_off_r <= supply_c_off_nxt;
      flag_out_sync_out_pin <= flag_pin_nxt;
    end
  end

  // bit 7 is reserved; the zero fill leaves it clear
  logic [DATA_W-1:0] flags_four;
  always_comb begin
    flags_four = '0;
    flags_four[F4_SUPPLY_C_OFF] = supply_c_off_r;
    flags_four[F4_FLAG_PIN] = flag_out_sync_out_pin;
    flags_four[F4_NVM_UNLOCKED] = sync_r[S_UNLOCKED];
    flags_four[F4_RAMP_B] = sync_r[S_RAMP_B];
    flags_four[F4_RAMP_A] = sync_r[S_RAMP_A];
    flags_four[F4_CLAMP_B] = sync_r[S_CLAMP_B];
    flags_four[F4_CLAMP_A] = sync_r[S_CLAMP_A];
  end

  ////////////////////////////////////////////////////////////////////////////
  // condition_flags_five, live and sticky

  logic [F5_W-1:0] flags_five;
  logic [F5_W-1:0] sticky_r;
  logic [F5_W-1:0] sticky_nxt;

  assign flags_five[F5_ZONE2_WARN] = sync_r[S_ZONE2_WARN];
  assign flags_five[F5_ZONE1_WARN] = sync_r[S_ZONE1_WARN];
  assign flags_five[F5_REV_B] = fault_now[ID_REV_B-1];
  assign flags_five[F5_REV_A] = fault_now[ID_REV_A-1];

  logic [F5_W-1:0] sticky_clr;

  assign sticky_clr = wr_sticky ? reg_wdata[F5_W-1:0] : '0;
  // write one clears, a present condition sets again in the same cycle
  assign sticky_nxt = flags_five | (sticky_r & ~sticky_clr);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sticky_r <= '0;
    end else begin
      sticky_r <= sticky_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shutdown cause recorders, one per regulated channel

  logic [1:0] run_ch;
  logic [NUM_FAULTS-1:0] enables_ch [2];
  logic [DATA_W-1:0] cause_r [2];
  logic [1:0] recorded;

  assign run_ch[0] = sync_r[S_RUN_A];
  assign run_ch[1] = sync_r[S_RUN_B];
  assign enables_ch[0] = chan_a_shutdown_enables;
  assign enables_ch[1] = chan_b_shutdown_enables;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_rec
      rec_state_type state_r;
      rec_state_type state_nxt;
      logic [NUM_FAULTS-1:0] trig;
      logic any_trig;
      logic take;
      logic [ID_W-1:0] new_id;
      logic [DATA_W-1:0] cause_nxt;

      // enables are same-clock configuration and need no synchroniser
      assign trig = fault_now & enables_ch[ch];
      assign any_trig = |trig;
      // only a flag seen while armed is taken; later ones wait for the next restart
      assign take = (state_r == REC_ARMED) && any_trig;
      assign new_id = first_id(trig);
      // current moves into previous on the same edge that the new cause lands
      assign cause_nxt = take ? {cause_r[ch][CUR_LSB +: ID_W], new_id} : cause_r[ch];

      always_comb begin
        state_nxt = state_r;
        unique case (state_r)
          REC_IDLE: begin
            if (run_ch[ch] && !any_trig) begin
              state_nxt = REC_ARMED;
            end
          end
          REC_ARMED: begin
            if (take) begin
              state_nxt = REC_HELD;
            end else if (!run_ch[ch]) begin
              state_nxt = REC_IDLE;
            end
          end
          REC_HELD: begin
            // rearm only after the channel has stopped and soft-started again
            if (!run_ch[ch]) begin
              state_nxt = REC_IDLE;
            end
          end
          default: begin
            state_nxt = REC_IDLE;
          end
        endcase
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          state_r <= REC_IDLE;
          cause_r[ch] <= '0;
        end else begin
          state_r <= state_nxt;
          cause_r[ch] <= cause_nxt;
        end
      end

      assign recorded[ch] = take;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_status_nxt;
  logic [IRQ_W-1:0] irq_mask_nxt;
  logic [IRQ_W-1:0] status_clr;
  logic [IRQ_W-1:0] irq_pending;
  logic [F5_W-1:0] sticky_rise;
  logic irq_nxt;

  assign irq_event[IRQ_CAUSE_A] = recorded[0];
  assign irq_event[IRQ_CAUSE_B] = recorded[1];
  // rising edge of any sticky bit, so a held condition raises one event only
  assign sticky_rise = sticky_nxt & ~sticky_r;
  assign irq_event[IRQ_STICKY] = |sticky_rise;
  assign status_clr = wr_status ? reg_wdata[IRQ_W-1:0] : '0;
  // set wins over a clear that lands in the same cycle
  assign irq_status_nxt = irq_event | (irq_status_r & ~status_clr);
  assign irq_mask_nxt = wr_mask ? reg_wdata[IRQ_W-1:0] : irq_mask_r;
  assign irq_pending = irq_status_r & irq_mask_r;
  // irq lags status by one edge because it comes straight from a flop
  assign irq_nxt = |irq_pending;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_r <= '0;
      irq_mask_r <= '0;
      irq <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [DATA_W-1:0] five_word;
  logic [DATA_W-1:0] sticky_word;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] mask_word;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_nxt;

  // reserved bits above each field read zero
  assign five_word = {{(DATA_W-F5_W){1'b0}}, flags_five};
  assign sticky_word = {{(DATA_W-F5_W){1'b0}}, sticky_r};
  assign status_word = {{(DATA_W-IRQ_W){1'b0}}, irq_status_r};
  assign mask_word = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r};
  // one-hot selects feed an and-or tree; an unmapped address selects nothing and reads zero
  assign rd_mux = ({DATA_W{sel_four}} & flags_four)
    | ({DATA_W{sel_five}} & five_word)
    | ({DATA_W{sel_sticky}} & sticky_word)
    | ({DATA_W{sel_cause_a}} & cause_r[0])
    | ({DATA_W{sel_cause_b}} & cause_r[1])
    | ({DATA_W{sel_status}} & status_word)
    | ({DATA_W{sel_mask}} & mask_word);

  // data stand for one cycle only, zero otherwise
  assign rdata_nxt = reg_read ? rd_mux : '0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule

// [verif/fault_flag_status_bank_properties.sv]
// checker for the register port, interrupt mask and flag pin of the fault flag status bank
`timescale 1ns/1ps
module fault_flag_status_bank_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [fault_flag_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fault_flag_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [fault_flag_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq,
  input wire logic chan_a_light_load,
  input wire logic chan_b_light_load,
  input wire logic flag_pin_light_load_enable,
  input wire logic flag_out_sync_out_pin
);
  import fault_flag_pkg::*;
  logic mapped;
  logic [2:0] wlow;
  assign mapped = reg_addr inside {ADDR_FLAGS_FOUR, ADDR_FLAGS_FIVE, ADDR_FLAGS_FIVE_STICKY,
    ADDR_CHAN_A_CAUSE, ADDR_CHAN_B_CAUSE, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
  assign wlow = reg_wdata[2:0];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  sequence mask_zero_s;
    reg_write && reg_addr == ADDR_IRQ_MASK && wlow == 3'h0 ##1 !(reg_write && reg_addr == ADDR_IRQ_MASK);
  endsequence
  sequence mask_rd_s;
    reg_write && reg_addr == ADDR_IRQ_MASK ##1 !reg_write ##1 reg_read && reg_addr == ADDR_IRQ_MASK;
  endsequence
  ////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (reg_read && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  four_reserved_a: assert property (reg_read && reg_addr == ADDR_FLAGS_FOUR |=> !reg_rdata[7])
    else $error("reserved bit of flags four set");
  five_reserved_a: assert property (
    reg_read && (reg_addr == ADDR_FLAGS_FIVE || reg_addr == ADDR_FLAGS_FIVE_STICKY) |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved bits of flags five set");
  mask_rdback_a: assert property (mask_rd_s |=> reg_rdata == {5'h00, $past(wlow, 3)})
    else $error("mask readback differs from write");
  mask_off_a: assert property (mask_zero_s |=> !irq)
    else $error("irq high with mask cleared");
  pin_on_a: assert property (
    (flag_pin_light_load_enable && (chan_a_light_load || chan_b_light_load))[*4] |-> flag_out_sync_out_pin)
    else $error("flag pin low during enabled light load");
  pin_quiet_a: assert property ((!chan_a_light_load && !chan_b_light_load)[*4] |-> !flag_out_sync_out_pin)
    else $error("flag pin high without light load");
  pin_gate_a: assert property (!flag_pin_light_load_enable[*2] |-> !flag_out_sync_out_pin)
    else $error("flag pin high while disabled");
endmodule
bind fault_flag_status_bank fault_flag_status_bank_properties chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .irq(irq), .chan_a_light_load(chan_a_light_load),
  .chan_b_light_load(chan_b_light_load), .flag_pin_light_load_enable(flag_pin_light_load_enable),
  .flag_out_sync_out_pin(flag_out_sync_out_pin));

// [verif/tb.sv]
// self-checking bench for the fault flag status bank
`timescale 1ns/1ps
module tb;
  import fault_flag_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic irq;
  logic pin;
  logic [14:0] flt = 15'h0000; // fault id n sits at n-1
  // light a,b; ramp a,b; clamp a,b; unlocked; warn 1,2; c off; c request; run a,b
  logic [12:0] cnd = 13'h0000;
  logic en = 1'b0;
  logic [14:0] ena = 15'h0000;
  logic [14:0] enb = 15'h0000;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  fault_flag_status_bank dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .chan_a_primary_overcurrent(flt[0]), .chan_b_primary_overcurrent(flt[1]),
    .chan_a_secondary_overcurrent(flt[2]), .chan_b_secondary_overcurrent(flt[3]),
    .chan_a_overvoltage(flt[4]), .chan_b_overvoltage(flt[5]), .chan_a_undervoltage(flt[6]),
    .chan_b_undervoltage(flt[7]), .shared_overcurrent(flt[8]), .line_sense_low(flt[9]),
    .zone1_overtemp(flt[10]), .zone2_overtemp(flt[11]), .external_flag_input(flt[12]),
    .chan_a_secondary_sense(flt[13]), .chan_b_secondary_sense(flt[14]),
    .chan_a_light_load(cnd[0]), .chan_b_light_load(cnd[1]), .chan_a_ramp_filter_active(cnd[2]),
    .chan_b_ramp_filter_active(cnd[3]), .chan_a_loop_filter_clamped(cnd[4]),
    .chan_b_loop_filter_clamped(cnd[5]), .nvm_unlocked(cnd[6]), .zone1_temp_warning(cnd[7]),
    .zone2_temp_warning(cnd[8]), .chan_c_outputs_off(cnd[9]), .chan_c_power_on_request(cnd[10]),
    .chan_a_running(cnd[11]), .chan_b_running(cnd[12]), .flag_pin_light_load_enable(en),
    .chan_a_shutdown_enables(ena), .chan_b_shutdown_enables(enb), .flag_out_sync_out_pin(pin)
  );
  always #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // the whole run needs about 450 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      close_out;
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk8(reg_rdata, exp);
  endtask
  // async inputs get four edges to pass the synchronisers
  task automatic drv(input logic [12:0] c, input logic [14:0] f);
    @(posedge clk_sys);
    cnd <= c;
    flt <= f;
    cyc(4);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(ADDR_FLAGS_FOUR, 8'h40);
    rd(ADDR_FLAGS_FIVE, 8'h00);
    rd(ADDR_CHAN_A_CAUSE, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h00);
    rd(16'hfe00, 8'h00);
    chk1(irq, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_four;
    int cb[5] = '{2, 3, 4, 5, 6};
    int fb[5] = '{F4_RAMP_A, F4_RAMP_B, F4_CLAMP_A, F4_CLAMP_B, F4_NVM_UNLOCKED};
    for (int i = 0; i < 5; i++) begin
      drv(13'h0001 << cb[i], 15'h0000);
      rd(ADDR_FLAGS_FOUR, 8'h40 | (8'h01 << fb[i]));
    end
    drv(13'h0400, 15'h0000);
    rd(ADDR_FLAGS_FOUR, 8'h00);
    drv(13'h0200, 15'h0000);
    rd(ADDR_FLAGS_FOUR, 8'h40);
    drv(13'h0000, 15'h0000);
    rd(ADDR_FLAGS_FOUR, 8'h40);
    @(posedge clk_sys);
    en <= 1'b1;
    drv(13'h0002, 15'h0000);
    rd(ADDR_FLAGS_FOUR, 8'h60);
    chk1(pin, 1'b1);
    @(posedge clk_sys);
    en <= 1'b0;
    drv(13'h0000, 15'h0000);
    rd(ADDR_FLAGS_FOUR, 8'h40);
    chk1(pin, 1'b0);
    $display("test flags four done");
  endtask
  task automatic t_five;
    drv(13'h0180, 15'h6000);
    rd(ADDR_FLAGS_FIVE, 8'h0f);
    drv(13'h0000, 15'h0000);
    rd(ADDR_FLAGS_FIVE, 8'h00);
    rd(ADDR_FLAGS_FIVE_STICKY, 8'h0f);
    wr(ADDR_FLAGS_FIVE_STICKY, 8'h05);
    rd(ADDR_FLAGS_FIVE_STICKY, 8'h0a);
    wr(ADDR_FLAGS_FIVE, 8'hff);
    rd(ADDR_FLAGS_FIVE, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h04);
    wr(ADDR_IRQ_MASK, 8'hff);
    rd(ADDR_IRQ_MASK, 8'h07);
    chk1(irq, 1'b1);
    wr(ADDR_IRQ_MASK, 8'h00);
    rd(ADDR_IRQ_MASK, 8'h00);
    chk1(irq, 1'b0);
    wr(ADDR_IRQ_STATUS, 8'h04);
    wr(ADDR_FLAGS_FIVE_STICKY, 8'h0a);
    rd(ADDR_IRQ_STATUS, 8'h00);
    rd(ADDR_FLAGS_FIVE_STICKY, 8'h00);
    $display("test flags five done");
  endtask
  task automatic t_rec_b;
    logic [3:0] prev;
    prev = 4'h0;
    @(posedge clk_sys);
    enb <= 15'h7fff;
    for (int id = 1; id < 16; id++) begin
      drv(13'h0000, 15'h0000);
      drv(13'h1000, 15'h0000);
      drv(13'h1000, 15'h0001 << (id - 1));
      rd(ADDR_CHAN_B_CAUSE, {prev, 4'(id)});
      prev = 4'(id);
    end
    drv(13'h0000, 15'h0000);
    rd(ADDR_IRQ_STATUS, 8'h06);
    rd(ADDR_FLAGS_FIVE_STICKY, 8'h03);
    wr(ADDR_IRQ_STATUS, 8'h07);
    wr(ADDR_FLAGS_FIVE_STICKY, 8'h03);
    $display("test channel b recorder done");
  endtask
  task automatic t_rec_a;
    @(posedge clk_sys);
    ena <= 15'h7ffe;
    drv(13'h0800, 15'h0000);
    drv(13'h0800, 15'h0001);
    rd(ADDR_CHAN_A_CAUSE, 8'h00);
    drv(13'h0800, 15'h0015);
    drv(13'h0800, 15'h0017);
    rd(ADDR_CHAN_A_CAUSE, 8'h03);
    rd(ADDR_CHAN_B_CAUSE, 8'hef);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    rd(ADDR_IRQ_MASK, 8'h01);
    chk1(irq, 1'b1);
    wr(ADDR_IRQ_STATUS, 8'h01);
    rd(ADDR_IRQ_STATUS, 8'h00);
    chk1(irq, 1'b0);
    $display("test channel a recorder done");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_four;
    t_five;
    t_rec_b;
    t_rec_a;
    close_out;
  end
endmodule
